// >>> core/xpt_pkg.sv
package xpt_pkg;
	localparam int NUM_ROWS = 20;
	localparam int NUM_COLS = 20;
	localparam int MIN_LINES = 17;
	localparam int SLICE_W = 5;
	localparam int NUM_SLICES = 4;
	localparam int INTERLOCK_CNT = 40;
	localparam int SYNC_STAGES = 3;

	// Positions inside the packed pin vector that goes through the synchroniser
	localparam int POS_ROW = 0;
	localparam int POS_COL = POS_ROW + NUM_ROWS;
	localparam int POS_PH1 = POS_COL + NUM_COLS;
	localparam int POS_PH2 = POS_PH1 + 1;
	localparam int POS_PH3 = POS_PH2 + 1;
	localparam int POS_PSU = POS_PH3 + 1;
	localparam int POS_ILK = POS_PSU + 1;
	localparam int PIN_W = POS_ILK + INTERLOCK_CNT;

	// Reset values: strobes and selects idle high, supply off, interlocks open
	localparam logic [PIN_W-1:0] PIN_RST = {{INTERLOCK_CNT{1'b1}}, 1'b0, {(PIN_W-INTERLOCK_CNT-1){1'b1}}};
	localparam logic [NUM_ROWS-1:0] ROW_CMD_RST = '0;
	localparam logic [NUM_COLS-1:0] COL_CMD_RST = '0;
	localparam logic PSU_STATUS_N_RST = 1'b1;
	localparam logic [INTERLOCK_CNT-1:0] ILK_STATUS_N_RST = '1;

	typedef logic [NUM_ROWS-1:0] row_vec_t;
	typedef logic [NUM_COLS-1:0] col_vec_t;
	typedef logic [SLICE_W-1:0] slice_vec_t;
endpackage

// >>> core/driver_slice.sv
module driver_slice
	import xpt_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_reset,
	input wire xpt_pkg::slice_vec_t i_sel,
	input wire logic i_en_turn,
	input wire logic i_en_sel_thru,
	input wire logic i_en_other_thru,
	output xpt_pkg::slice_vec_t o_turn,
	output xpt_pkg::slice_vec_t o_thru
);
	import xpt_pkg::*;

	slice_vec_t turn_q;
	slice_vec_t thru_q;

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			turn_q <= '0;
		end else begin
			turn_q <= i_sel & {SLICE_W{i_en_turn}};
		end
	end

	// Selected lines take one enable, unselected lines the other
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			thru_q <= '0;
		end else begin
			thru_q <= (i_sel & {SLICE_W{i_en_sel_thru}}) | (~i_sel & {SLICE_W{i_en_other_thru}});
		end
	end

	assign o_turn = turn_q;
	assign o_thru = thru_q;
endmodule // driver_slice

// >>> core/crosspoint_phase_driver.sv
// Operation
// - Controller gives row, column and phases; block turns crosspoint, clears row and column.
// - Phase 1 low drives Thru on the selected row, all columns enabled.
// - Two-phase Phase 2 turns row-column crosspoint and clears the selected column.
// - Three-phase Phase 2 alone only turns the row-column crosspoint.
// - Three-phase Phase 3 with Phase 2 clears the selected column to Thru.
// - Matrix of seventeen up to twenty rows by twenty columns.
// - Four row slices and four column slices of five lines each.
// - Actuator supply state returned as contact closure to the controller.
// - Each phase strobe is an active-low enable for its driver outputs.
module crosspoint_phase_driver
	import xpt_pkg::*;
(
	input wire logic I_CLK_SYS,
	input wire logic I_RESET,
	input wire logic I_THREE_PHASE,
	input wire xpt_pkg::row_vec_t I_ROW_SEL_N,
	input wire xpt_pkg::col_vec_t I_COL_SEL_N,
	input wire logic I_PHASE1_N,
	input wire logic I_PHASE2_N,
	input wire logic I_PHASE3_N,
	input wire logic I_PSU_OK,
	input wire logic [xpt_pkg::INTERLOCK_CNT-1:0] I_INTERLOCK_N,
	output xpt_pkg::row_vec_t O_ROW_TURN,
	output xpt_pkg::row_vec_t O_ROW_THRU,
	output xpt_pkg::col_vec_t O_COL_EN,
	output logic O_PSU_STATUS_N,
	output logic [xpt_pkg::INTERLOCK_CNT-1:0] O_INTERLOCK_N,
	output logic O_ADDR_FAULT,
	output logic O_PHASE_ACTIVE
);
	import xpt_pkg::*;

	logic [PIN_W-1:0] pins;
	logic [PIN_W-1:0] sync1_q;
	logic [PIN_W-1:0] sync2_q;
	logic [PIN_W-1:0] sync3_q;
	logic [PIN_W-1:0] filt_q;
	row_vec_t row_sel;
	col_vec_t col_sel;
	logic p1;
	logic p2;
	logic p3;
	logic any_phase;
	logic addr_ok;
	logic seq_ok;
	logic row_en_turn;
	logic row_en_sel_thru;
	logic row_en_other_thru;
	logic col_en_sel;
	logic col_en_other;
	logic psu_status_n_q;
	logic [INTERLOCK_CNT-1:0] ilk_q;
	logic addr_fault_q;
	logic phase_active_q;
	row_vec_t row_turn;
	row_vec_t row_thru;
	col_vec_t col_en;

	function automatic logic one_hot20(input logic [NUM_ROWS-1:0] v);
		logic [NUM_ROWS-1:0] m;
		m = v & (v - 1'b1);
		return (v != '0) && (m == '0);
	endfunction

	assign pins = {I_INTERLOCK_N, I_PSU_OK, I_PHASE3_N, I_PHASE2_N, I_PHASE1_N,
		I_COL_SEL_N, I_ROW_SEL_N};

	// Three-stage sampler; a level is taken only once stages two and three agree
	always_ff @(posedge I_CLK_SYS) begin
		if (I_RESET) begin
			sync1_q <= PIN_RST;
			sync2_q <= PIN_RST;
			sync3_q <= PIN_RST;
		end else begin
			sync1_q <= pins;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	always_ff @(posedge I_CLK_SYS) begin
		if (I_RESET) begin
			filt_q <= PIN_RST;
		end else begin
			for (int i = 0; i < PIN_W; i++) begin
				if (sync2_q[i] == sync3_q[i]) begin
					filt_q[i] <= sync3_q[i];
				end
			end
		end
	end

	assign row_sel = ~filt_q[POS_ROW +: NUM_ROWS];
	assign col_sel = ~filt_q[POS_COL +: NUM_COLS];
	assign p1 = ~filt_q[POS_PH1];
	assign p2 = ~filt_q[POS_PH2];
	assign p3 = ~filt_q[POS_PH3];
	assign any_phase = p1 | p2;

	// A malformed address or overlapping Phase 1 and 2 would pull a whole
	// bus of actuators at once; drive nothing rather than guess
	assign addr_ok = one_hot20(row_sel) && one_hot20(col_sel);
	assign seq_ok = addr_ok && !(p1 && p2);

	assign row_en_sel_thru = seq_ok && p1;
	assign row_en_turn = seq_ok && p2;
	// Column clear: implied by Phase 2 in two-phase, needs Phase 3 in three-phase
	assign row_en_other_thru = seq_ok && p2 && (!I_THREE_PHASE || p3);
	assign col_en_sel = seq_ok && (p1 || p2);
	assign col_en_other = seq_ok && p1;

	genvar g;
	generate
		for (g = 0; g < NUM_SLICES; g++) begin : g_slice
			driver_slice u_row (
				.i_clk(I_CLK_SYS),
				.i_reset(I_RESET),
				.i_sel(row_sel[g*SLICE_W +: SLICE_W]),
				.i_en_turn(row_en_turn),
				.i_en_sel_thru(row_en_sel_thru),
				.i_en_other_thru(row_en_other_thru),
				.o_turn(row_turn[g*SLICE_W +: SLICE_W]),
				.o_thru(row_thru[g*SLICE_W +: SLICE_W])
			);
			driver_slice u_col (
				.i_clk(I_CLK_SYS),
				.i_reset(I_RESET),
				.i_sel(col_sel[g*SLICE_W +: SLICE_W]),
				.i_en_turn(1'b0),
				.i_en_sel_thru(col_en_sel),
				.i_en_other_thru(col_en_other),
				.o_turn(),
				.o_thru(col_en[g*SLICE_W +: SLICE_W])
			);
		end
	endgenerate

	// Lines beyond a smaller matrix simply stay unselected by the controller
	assign O_ROW_TURN = row_turn;
	assign O_ROW_THRU = row_thru;
	assign O_COL_EN = col_en;

	// Closure to common, i.e. low, while the actuator supply runs
	always_ff @(posedge I_CLK_SYS) begin
		if (I_RESET) begin
			psu_status_n_q <= PSU_STATUS_N_RST;
		end else begin
			psu_status_n_q <= ~filt_q[POS_PSU];
		end
	end

	always_ff @(posedge I_CLK_SYS) begin
		if (I_RESET) begin
			ilk_q <= ILK_STATUS_N_RST;
		end else begin
			ilk_q <= filt_q[POS_ILK +: INTERLOCK_CNT];
		end
	end

	always_ff @(posedge I_CLK_SYS) begin
		if (I_RESET) begin
			addr_fault_q <= 1'b0;
			phase_active_q <= 1'b0;
		end else begin
			addr_fault_q <= any_phase && !seq_ok;
			phase_active_q <= any_phase;
		end
	end

	assign O_PSU_STATUS_N = psu_status_n_q;
	assign O_INTERLOCK_N = ilk_q;
	assign O_ADDR_FAULT = addr_fault_q;
	assign O_PHASE_ACTIVE = phase_active_q;
endmodule // crosspoint_phase_driver

// >>> tb/xpt_chk_sva.sv
module xpt_chk
	import xpt_pkg::*;
(
	input wire logic I_CLK_SYS,
	input wire logic I_RESET,
	input wire logic I_THREE_PHASE,
	input wire xpt_pkg::row_vec_t I_ROW_SEL_N,
	input wire xpt_pkg::col_vec_t I_COL_SEL_N,
	input wire logic I_PHASE1_N,
	input wire logic I_PHASE2_N,
	input wire logic I_PHASE3_N,
	input wire logic I_PSU_OK,
	input wire xpt_pkg::row_vec_t O_ROW_TURN,
	input wire xpt_pkg::row_vec_t O_ROW_THRU,
	input wire xpt_pkg::col_vec_t O_COL_EN,
	input wire logic O_PSU_STATUS_N,
	input wire logic O_ADDR_FAULT
);
	logic [44:0] pins_q;
	logic [3:0] calm_q;
	wire logic [44:0] pins = {I_THREE_PHASE, I_ROW_SEL_N, I_COL_SEL_N,
		I_PHASE1_N, I_PHASE2_N, I_PHASE3_N, I_PSU_OK};
	// Outputs only judged once the pins have outlived the sampler
	// The pins must also match last cycle's copy, or the first cycle after a change passes
	wire logic calm = (calm_q > 4'h5) && (pins == pins_q);
	wire logic ok = calm && !O_ADDR_FAULT;
	wire logic p1 = !I_PHASE1_N && I_PHASE2_N;
	wire logic p2 = I_PHASE1_N && !I_PHASE2_N;
	always_ff @(posedge I_CLK_SYS) begin
		pins_q <= pins;
		if (I_RESET || pins != pins_q)
			calm_q <= '0;
		else if (calm_q != 4'hf)
			calm_q <= calm_q + 4'h1;
	end
	default clocking cb @(posedge I_CLK_SYS); endclocking
	default disable iff (I_RESET);
	a_idle_no_cmd: assert property (calm && I_PHASE1_N && I_PHASE2_N
		|-> O_ROW_TURN == '0 && O_ROW_THRU == '0 && O_COL_EN == '0) else $error("stray drive");
	a_row_clear: assert property (ok && p1
		|-> O_ROW_THRU == ~I_ROW_SEL_N && O_ROW_TURN == '0 && O_COL_EN == '1)
		else $error("row clear wrong");
	a_turn_point: assert property (ok && p2
		|-> O_ROW_TURN == ~I_ROW_SEL_N && O_COL_EN == ~I_COL_SEL_N) else $error("turn wrong");
	a_col_clear: assert property (ok && p2 && !(I_THREE_PHASE && I_PHASE3_N)
		|-> O_ROW_THRU == I_ROW_SEL_N) else $error("column clear wrong");
	a_turn_only: assert property (ok && p2 && I_THREE_PHASE && I_PHASE3_N
		|-> O_ROW_THRU == '0) else $error("thru without phase 3");
	a_psu_state: assert property (calm |-> O_PSU_STATUS_N == !I_PSU_OK)
		else $error("supply status wrong");
	a_overlap_fault: assert property (calm && !I_PHASE1_N && !I_PHASE2_N
		|-> O_ADDR_FAULT && O_ROW_TURN == '0) else $error("overlap not refused");
	a_turn_drop: assert property ($rose(I_PHASE2_N) ##1 I_PHASE2_N [*5]
		|-> O_ROW_TURN == '0) else $error("turn outlived phase 2");
	c_row_clear: cover property (ok && p1);
	c_three_clear: cover property (ok && p2 && I_THREE_PHASE && !I_PHASE3_N);
	c_fault: cover property (calm && O_ADDR_FAULT);
endmodule // xpt_chk

// >>> tb/xpt_ctl_model.sv
module xpt_ctl_model
	import xpt_pkg::*;
(
	input wire logic i_clk,
	output xpt_pkg::row_vec_t o_row_n,
	output xpt_pkg::col_vec_t o_col_n,
	output logic [2:0] o_ph_n
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		o_row_n = '1;
		o_col_n = '1;
		o_ph_n = 3'h7;
	end
	// Strobes as {ph3, ph2, ph1}; callers never overlap phase 1 and 2 unless testing refusal
	task automatic apply(input row_vec_t r, input col_vec_t c, input logic [2:0] p);
		@(posedge i_clk);
		o_row_n <= r;
		o_col_n <= c;
		o_ph_n <= p;
		repeat (8) @(posedge i_clk);
	endtask
endmodule // xpt_ctl_model

// >>> tb/test_crosspoint_phase_driver.sv
module test_crosspoint_phase_driver;
	timeunit 1ns;
	timeprecision 1ps;
	import xpt_pkg::*;
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
	$display("ERROR %s exp %h got %h", nm, e, g); end end
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic three = 1'b0;
	logic psu = 1'b0;
	logic [39:0] ilk = '1;
	int fails = 0;
	int n_checks = 0;
	row_vec_t row_n, turn, thru;
	col_vec_t col_n, col_en;
	logic [2:0] ph_n;
	logic [39:0] ilk_o;
	logic psu_n, fault, act;
	initial forever #2.5 clk = ~clk;
	xpt_ctl_model ctl (.i_clk(clk), .o_row_n(row_n), .o_col_n(col_n), .o_ph_n(ph_n));
	crosspoint_phase_driver dut (.I_CLK_SYS(clk), .I_RESET(rst), .I_THREE_PHASE(three),
		.I_ROW_SEL_N(row_n), .I_COL_SEL_N(col_n), .I_PHASE1_N(ph_n[0]),
		.I_PHASE2_N(ph_n[1]), .I_PHASE3_N(ph_n[2]), .I_PSU_OK(psu), .I_INTERLOCK_N(ilk),
		.O_ROW_TURN(turn), .O_ROW_THRU(thru), .O_COL_EN(col_en), .O_PSU_STATUS_N(psu_n),
		.O_INTERLOCK_N(ilk_o), .O_ADDR_FAULT(fault), .O_PHASE_ACTIVE(act));
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic expect3(input row_vec_t t, input row_vec_t h, input col_vec_t c);
		`CHK("row_turn", t, turn)
		`CHK("row_thru", h, thru)
		`CHK("col_en", c, col_en)
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		end_of_test();
	end
	initial begin
		row_vec_t r;
		col_vec_t c;
		// Slice edges on both row and column sides
		int rs[3] = '{0, 5, 19};
		int cs[3] = '{4, 19, 10};
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		ctl.apply('1, '1, 3'h7);
		expect3('0, '0, '0);
		`CHK("psu_n", 1'b1, psu_n)
		psu <= 1'b1;
		ilk <= 40'h5a_c3f0_0f96;
		ctl.apply('1, '1, 3'h7);
		`CHK("psu_n", 1'b0, psu_n)
		`CHK("ilk", 40'h5a_c3f0_0f96, ilk_o)
		for (int m = 0; m < 2; m++) begin
			three <= m[0];
			for (int k = 0; k < 3; k++) begin
				r = ~(row_vec_t'(1) << rs[k]);
				c = ~(col_vec_t'(1) << cs[k]);
				ctl.apply(r, c, 3'h6);
				expect3('0, ~r, '1);
				`CHK("active", 1'b1, act)
				ctl.apply(r, c, 3'h7);
				expect3('0, '0, '0);
				`CHK("active", 1'b0, act)
				ctl.apply(r, c, 3'h1);
				expect3(~r, r, ~c);
				ctl.apply(r, c, 3'h5);
				expect3(~r, (m == 1) ? '0 : r, ~c);
			end
		end
		ctl.apply(20'hffffc, 20'hffffe, 3'h6);
		expect3('0, '0, '0);
		`CHK("fault", 1'b1, fault)
		ctl.apply(20'hffffe, 20'hffffe, 3'h4);
		`CHK("fault", 1'b1, fault)
		ctl.apply('1, '1, 3'h7);
		end_of_test();
	end
endmodule // test_crosspoint_phase_driver
bind crosspoint_phase_driver xpt_chk chk (.I_CLK_SYS(I_CLK_SYS), .I_RESET(I_RESET),
	.I_THREE_PHASE(I_THREE_PHASE), .I_ROW_SEL_N(I_ROW_SEL_N), .I_COL_SEL_N(I_COL_SEL_N),
	.I_PHASE1_N(I_PHASE1_N), .I_PHASE2_N(I_PHASE2_N), .I_PHASE3_N(I_PHASE3_N),
	.I_PSU_OK(I_PSU_OK), .O_ROW_TURN(O_ROW_TURN), .O_ROW_THRU(O_ROW_THRU),
	.O_COL_EN(O_COL_EN), .O_PSU_STATUS_N(O_PSU_STATUS_N), .O_ADDR_FAULT(O_ADDR_FAULT));
